// ==== verilog/irq_flags_pkg.sv ====
// Package: register map, field layout and bus carriers of the event flag block
package irq_flags_pkg;

   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int unsigned ADDR_W = 18;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned STRB_W = 4;
   localparam int unsigned FLAG_W = 4;
   localparam int unsigned IDX_W  = 16;

   // ----------------------------------------------------------------
   // Register indices, byte address is four times the index
   // ----------------------------------------------------------------
   localparam logic [IDX_W-1:0] KEY_FLAGS_IDX  = 16'hFFFC;
   localparam logic [IDX_W-1:0] SW_FLAGS_IDX   = 16'hFFFD;
   localparam logic [IDX_W-1:0] TICK_FLAGS_IDX = 16'hFFFE;
   localparam logic [IDX_W-1:0] KEY_MASK_IDX   = 16'hFFF0;
   localparam logic [IDX_W-1:0] SW_MASK_IDX    = 16'hFFF1;
   localparam logic [IDX_W-1:0] TICK_MASK_IDX  = 16'hFFF2;
   localparam logic [1:0]       WORD_ALIGN     = 2'h0;

   // ----------------------------------------------------------------
   // Reset values and field positions
   // ----------------------------------------------------------------
   localparam logic [FLAG_W-1:0] FLAG_RST = 4'h0;
   localparam logic [FLAG_W-1:0] MASK_RST = 4'h0;
   localparam logic [FLAG_W-1:0] LINE_IDLE = 4'hF;
   localparam int unsigned SW_RUN_BIT     = 3;
   localparam int unsigned SW_LAP_BIT     = 2;
   localparam int unsigned SW_1HZ_BIT     = 1;
   localparam int unsigned SW_10HZ_BIT    = 0;
   localparam int unsigned TICK_16HZ_BIT  = 3;
   localparam int unsigned TICK_32HZ_BIT  = 2;
   localparam int unsigned TICK_64HZ_BIT  = 1;
   localparam int unsigned TICK_128HZ_BIT = 0;
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic              awvalid;
      logic [ADDR_W-1:0] awaddr;
      logic              wvalid;
      logic [DATA_W-1:0] wdata;
      logic [STRB_W-1:0] wstrb;
      logic              bready;
      logic              arvalid;
      logic [ADDR_W-1:0] araddr;
      logic              rready;
   } axil_req_s;

   typedef struct packed {
      logic              awready;
      logic              wready;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              arready;
      logic              rvalid;
      logic [DATA_W-1:0] rdata;
      logic [1:0]        rresp;
   } axil_rsp_s;

   // Field order matches D3..D0
   typedef struct packed {
      logic direct_go;
      logic direct_split;
      logic chrono_one_hz;
      logic chrono_ten_hz;
   } chrono_evt_s;

   typedef struct packed {
      logic tick_16hz;
      logic tick_32hz;
      logic tick_64hz;
      logic tick_128hz;
   } tick_evt_s;

   typedef enum logic [2:0] {
      SEL_NONE,
      SEL_KEY,
      SEL_SW,
      SEL_TICK,
      SEL_KEY_MASK,
      SEL_SW_MASK,
      SEL_TICK_MASK
   } reg_sel_e;

endpackage

// ==== verilog/event_sync.sv ====
// Key line synchroniser with press detection
`timescale 1ns/1ps
module event_sync
   import irq_flags_pkg::*;
#(
   parameter int unsigned WIDTH = FLAG_W
)(
   input  wire logic             clk_sys_i,
   input  wire logic             arst_n_i,
   input  wire logic [WIDTH-1:0] line_n_i,
   output logic      [WIDTH-1:0] press_o
);

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] sync;
      logic [WIDTH-1:0] prev;
      logic [WIDTH-1:0] press;
   } sync_state_s;

   sync_state_s st_ff;
   sync_state_s nxt_st;

   if (WIDTH < 1 || WIDTH > FLAG_W) begin : g_bad_width
      $error("event_sync: WIDTH out of range");
   end

   // Meta stage feeds only the sync stage
   always_comb begin
      nxt_st       = st_ff;
      nxt_st.meta  = line_n_i;
      nxt_st.sync  = st_ff.meta;
      nxt_st.prev  = st_ff.sync;
      nxt_st.press = st_ff.prev & ~st_ff.sync;
   end

   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st_ff <= '{meta: '1, sync: '1, prev: '1, press: '0};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign press_o = st_ff.press;

endmodule

// ==== verilog/flag_bank.sv ====
// Sticky event flags, set by hardware, cleared by writing ones
`timescale 1ns/1ps
module flag_bank
   import irq_flags_pkg::*;
#(
   parameter int unsigned WIDTH = FLAG_W
)(
   input  wire logic             clk_sys_i,
   input  wire logic             arst_n_i,
   input  wire logic [WIDTH-1:0] set_i,
   input  wire logic [WIDTH-1:0] clr_i,
   output logic      [WIDTH-1:0] flags_o
);

   typedef struct packed {
      logic [WIDTH-1:0] flags;
   } bank_state_s;

   bank_state_s st_ff;
   bank_state_s nxt_st;

   if (WIDTH < 1 || WIDTH > FLAG_W) begin : g_bad_width
      $error("flag_bank: WIDTH out of range");
   end

   always_comb begin
      nxt_st       = st_ff;
      nxt_st.flags = (st_ff.flags & ~clr_i) | set_i;
   end

   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st_ff.flags <= FLAG_RST[WIDTH-1:0];
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign flags_o = st_ff.flags;

endmodule

// ==== verilog/interrupt_factor_flags.sv ====
// Interrupt event flag registers with AXI4-Lite access and masked interrupt
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ps
module interrupt_factor_flags
   import irq_flags_pkg::*;
(
   input  wire logic              clk_sys_i,
   input  wire logic              arst_n_i,
   input  wire axil_req_s         axil_req_i,
   output axil_rsp_s              axil_rsp_o,
   input  wire logic [FLAG_W-1:0] keyline_n_i,
   input  wire chrono_evt_s       chrono_evt_i,
   input  wire tick_evt_s         tick_evt_i,
   output logic                   irq_o
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic              aw_ok;
      logic [ADDR_W-1:0] aw_addr;
      logic              w_ok;
      logic [DATA_W-1:0] w_data;
      logic [STRB_W-1:0] w_strb;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              rvalid;
      logic [DATA_W-1:0] rdata;
      logic [1:0]        rresp;
      logic [FLAG_W-1:0] key_mask;
      logic [FLAG_W-1:0] sw_mask;
      logic [FLAG_W-1:0] tick_mask;
   } slave_state_s;

   localparam slave_state_s ST_RST = '{
      aw_ok: 1'b0, aw_addr: '0, w_ok: 1'b0, w_data: '0, w_strb: '0,
      bvalid: 1'b0, bresp: RESP_OKAY, rvalid: 1'b0, rdata: '0,
      rresp: RESP_OKAY, key_mask: MASK_RST, sw_mask: MASK_RST,
      tick_mask: MASK_RST
   };

   slave_state_s      st_ff;
   slave_state_s      nxt_st;
   logic [FLAG_W-1:0] key_press;
   logic [FLAG_W-1:0] key_flags;
   logic [FLAG_W-1:0] sw_flags;
   logic [FLAG_W-1:0] tick_flags;
   logic [FLAG_W-1:0] sw_set;
   logic [FLAG_W-1:0] tick_set;
   logic [FLAG_W-1:0] key_clr;
   logic [FLAG_W-1:0] sw_clr;
   logic [FLAG_W-1:0] tick_clr;
   logic              awready;
   logic              wready;
   logic              arready;
   logic              aw_have;
   logic              w_have;
   logic              wr_fire;
   logic              rd_take;
   logic [ADDR_W-1:0] wr_addr;
   logic [DATA_W-1:0] wr_data;
   logic [STRB_W-1:0] wr_strb;
   reg_sel_e          wr_sel;
   reg_sel_e          rd_sel;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic reg_sel_e decode_sel(input logic [ADDR_W-1:0] addr);
      reg_sel_e sel;
      sel = SEL_NONE;
      if (addr[1:0] == WORD_ALIGN) begin
         unique case (addr[ADDR_W-1:2])
            KEY_FLAGS_IDX:  sel = SEL_KEY;
            SW_FLAGS_IDX:   sel = SEL_SW;
            TICK_FLAGS_IDX: sel = SEL_TICK;
            KEY_MASK_IDX:   sel = SEL_KEY_MASK;
            SW_MASK_IDX:    sel = SEL_SW_MASK;
            TICK_MASK_IDX:  sel = SEL_TICK_MASK;
            default:        sel = SEL_NONE;
         endcase
      end
      return sel;
   endfunction

   function automatic logic [DATA_W-1:0] widen(input logic [FLAG_W-1:0] v);
      return {{(DATA_W-FLAG_W){1'b0}}, v};
   endfunction

   // ----------------------------------------------------------------
   // Event sources
   // ----------------------------------------------------------------
   event_sync #(
      .WIDTH     (FLAG_W)
   ) u_key_sync (
      .clk_sys_i (clk_sys_i),
      .arst_n_i  (arst_n_i),
      .line_n_i  (keyline_n_i),
      .press_o   (key_press)
   );

   always_comb begin
      sw_set                 = '0;
      sw_set[SW_RUN_BIT]     = chrono_evt_i.direct_go;
      sw_set[SW_LAP_BIT]     = chrono_evt_i.direct_split;
      sw_set[SW_1HZ_BIT]     = chrono_evt_i.chrono_one_hz;
      sw_set[SW_10HZ_BIT]    = chrono_evt_i.chrono_ten_hz;
      tick_set               = '0;
      tick_set[TICK_16HZ_BIT]  = tick_evt_i.tick_16hz;
      tick_set[TICK_32HZ_BIT]  = tick_evt_i.tick_32hz;
      tick_set[TICK_64HZ_BIT]  = tick_evt_i.tick_64hz;
      tick_set[TICK_128HZ_BIT] = tick_evt_i.tick_128hz;
   end

   // ----------------------------------------------------------------
   // Flag registers
   // ----------------------------------------------------------------
   flag_bank #(
      .WIDTH     (FLAG_W)
   ) u_key_flags (
      .clk_sys_i (clk_sys_i),
      .arst_n_i  (arst_n_i),
      .set_i     (key_press),
      .clr_i     (key_clr),
      .flags_o   (key_flags)
   );

   flag_bank #(
      .WIDTH     (FLAG_W)
   ) u_sw_flags (
      .clk_sys_i (clk_sys_i),
      .arst_n_i  (arst_n_i),
      .set_i     (sw_set),
      .clr_i     (sw_clr),
      .flags_o   (sw_flags)
   );

   flag_bank #(
      .WIDTH     (FLAG_W)
   ) u_tick_flags (
      .clk_sys_i (clk_sys_i),
      .arst_n_i  (arst_n_i),
      .set_i     (tick_set),
      .clr_i     (tick_clr),
      .flags_o   (tick_flags)
   );

   // ----------------------------------------------------------------
   // Bus slave
   // ----------------------------------------------------------------
   assign awready = !st_ff.aw_ok && !st_ff.bvalid;
   assign wready  = !st_ff.w_ok && !st_ff.bvalid;
   assign arready = !st_ff.rvalid;
   assign aw_have = st_ff.aw_ok || (axil_req_i.awvalid && awready);
   assign w_have  = st_ff.w_ok || (axil_req_i.wvalid && wready);
   assign wr_fire = aw_have && w_have && !st_ff.bvalid;
   assign rd_take = axil_req_i.arvalid && arready;
   assign wr_addr = st_ff.aw_ok ? st_ff.aw_addr : axil_req_i.awaddr;
   assign wr_data = st_ff.w_ok ? st_ff.w_data : axil_req_i.wdata;
   assign wr_strb = st_ff.w_ok ? st_ff.w_strb : axil_req_i.wstrb;
   assign wr_sel  = decode_sel(wr_addr);
   assign rd_sel  = decode_sel(axil_req_i.araddr);

   // Ones clear, zeros are ignored
   always_comb begin
      key_clr  = '0;
      sw_clr   = '0;
      tick_clr = '0;
      if (wr_fire && wr_strb[0]) begin
         unique case (wr_sel)
            SEL_KEY:  key_clr  = wr_data[FLAG_W-1:0];
            SEL_SW:   sw_clr   = wr_data[FLAG_W-1:0];
            SEL_TICK: tick_clr = wr_data[FLAG_W-1:0];
            default:  ;
         endcase
      end
   end

   always_comb begin
      nxt_st = st_ff;
      if (st_ff.bvalid && axil_req_i.bready) begin
         nxt_st.bvalid = 1'b0;
      end
      if (wr_fire) begin
         nxt_st.aw_ok  = 1'b0;
         nxt_st.w_ok   = 1'b0;
         nxt_st.bvalid = 1'b1;
         nxt_st.bresp  = (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
         if (wr_strb[0]) begin
            unique case (wr_sel)
               SEL_KEY_MASK:  nxt_st.key_mask  = wr_data[FLAG_W-1:0];
               SEL_SW_MASK:   nxt_st.sw_mask   = wr_data[FLAG_W-1:0];
               SEL_TICK_MASK: nxt_st.tick_mask = wr_data[FLAG_W-1:0];
               default:       ;
            endcase
         end
      end else begin
         if (axil_req_i.awvalid && awready) begin
            nxt_st.aw_ok   = 1'b1;
            nxt_st.aw_addr = axil_req_i.awaddr;
         end
         if (axil_req_i.wvalid && wready) begin
            nxt_st.w_ok   = 1'b1;
            nxt_st.w_data = axil_req_i.wdata;
            nxt_st.w_strb = axil_req_i.wstrb;
         end
      end
      if (st_ff.rvalid && axil_req_i.rready) begin
         nxt_st.rvalid = 1'b0;
      end
      if (rd_take) begin
         nxt_st.rvalid = 1'b1;
         nxt_st.rresp  = RESP_OKAY;
         unique case (rd_sel)
            SEL_KEY:       nxt_st.rdata = widen(key_flags);
            SEL_SW:        nxt_st.rdata = widen(sw_flags);
            SEL_TICK:      nxt_st.rdata = widen(tick_flags);
            SEL_KEY_MASK:  nxt_st.rdata = widen(st_ff.key_mask);
            SEL_SW_MASK:   nxt_st.rdata = widen(st_ff.sw_mask);
            SEL_TICK_MASK: nxt_st.rdata = widen(st_ff.tick_mask);
            SEL_NONE: begin
               nxt_st.rdata = '0;
               nxt_st.rresp = RESP_SLVERR;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st_ff <= ST_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   always_comb begin
      axil_rsp_o         = '0;
      axil_rsp_o.awready = awready;
      axil_rsp_o.wready  = wready;
      axil_rsp_o.bvalid  = st_ff.bvalid;
      axil_rsp_o.bresp   = st_ff.bresp;
      axil_rsp_o.arready = arready;
      axil_rsp_o.rvalid  = st_ff.rvalid;
      axil_rsp_o.rdata   = st_ff.rdata;
      axil_rsp_o.rresp   = st_ff.rresp;
   end

   // ----------------------------------------------------------------
   // Interrupt
   // ----------------------------------------------------------------
   assign irq_o = |((key_flags & st_ff.key_mask) | (sw_flags & st_ff.sw_mask)
                    | (tick_flags & st_ff.tick_mask));

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   sequence key_read_take_s;
      rd_take && (rd_sel == SEL_KEY);
   endsequence

   sequence read_answer_s(logic [FLAG_W-1:0] v);
      st_ff.rvalid && (st_ff.rdata == widen(v)) && (st_ff.rresp == RESP_OKAY);
   endsequence

   property read_returns_flags_p;
      @(posedge clk_sys_i) disable iff (!arst_n_i)
      key_read_take_s |=> read_answer_s($past(key_flags));
   endproperty

   read_flags_a: assert property (read_returns_flags_p)
      else $error("key flag read returned wrong data");

   sequence sw_clear_write_s;
      wr_fire && wr_strb[0] && (wr_sel == SEL_SW);
   endsequence

   w1c_clear_a: assert property (
      @(posedge clk_sys_i) disable iff (!arst_n_i)
      sw_clear_write_s ##0 (sw_set == '0)
      |=> sw_flags == ($past(sw_flags) & ~$past(wr_data[FLAG_W-1:0])))
      else $error("write of ones did not clear stopwatch flags");

   zero_write_keeps_a: assert property (
      @(posedge clk_sys_i) disable iff (!arst_n_i)
      (tick_clr == '0) |=> (tick_flags & $past(tick_flags)) == $past(tick_flags))
      else $error("tick flag lost without a clearing write");

   key_layout_a: assert property (
      @(posedge clk_sys_i) disable iff (!arst_n_i)
      key_press[0] |=> key_flags[0])
      else $error("key line 0 press not shown in D0");

   key_press_path_a: assert property (
      @(posedge clk_sys_i) disable iff (!arst_n_i)
      $fell(u_key_sync.st_ff.sync[3]) |=> ##1 key_flags[3])
      else $error("key line 3 press not shown in D3");

   sw_layout_a: assert property (
      @(posedge clk_sys_i) disable iff (!arst_n_i)
      chrono_evt_i.direct_go |=> sw_flags[3])
      else $error("direct go event not shown in D3");

   tick_layout_a: assert property (
      @(posedge clk_sys_i) disable iff (!arst_n_i)
      tick_evt_i.tick_128hz |=> tick_flags[0])
      else $error("128 Hz tick not shown in D0");

   reset_clear_a: assert property (
      @(posedge clk_sys_i)
      $rose(arst_n_i) |-> (key_flags == FLAG_RST) && (sw_flags == FLAG_RST)
                          && (tick_flags == FLAG_RST))
      else $error("flags not zero after reset");

   set_wins_a: assert property (
      @(posedge clk_sys_i) disable iff (!arst_n_i)
      (tick_set != '0) && (tick_clr != '0)
      |=> (tick_flags & $past(tick_set)) == $past(tick_set))
      else $error("clear beat a coincident tick event");

   write_resp_a: assert property (
      @(posedge clk_sys_i) disable iff (!arst_n_i)
      wr_fire |=> st_ff.bvalid && !awready && !wready)
      else $error("write response missing");

   irq_follow_a: assert property (
      @(posedge clk_sys_i) disable iff (!arst_n_i)
      tick_set[0] && st_ff.tick_mask[0] && !(wr_fire && (wr_sel == SEL_TICK_MASK))
      |=> irq_o)
      else $error("unmasked event did not raise interrupt");

endmodule

// ==== testbench/tb_interrupt_factor_flags.sv ====
// Self-checking testbench of the interrupt event flag block
`timescale 1ns/1ps
module tb_interrupt_factor_flags;
   import irq_flags_pkg::*;

   // ----------------------------------------------------------------
   // Stimulus and observation
   // ----------------------------------------------------------------
   localparam tick_evt_s   T128 = '{tick_128hz: 1'b1, default: 1'b0};
   logic                   clk_sys_i = 1'b0;
   logic                   arst_n_i  = 1'b0;
   axil_req_s              req       = '0;
   axil_rsp_s              rsp;
   logic [FLAG_W-1:0]      keyline_n = LINE_IDLE;
   chrono_evt_s            chrono    = '0;
   tick_evt_s              tick      = '0;
   logic                   irq;
   int                     bad_count = 0;
   int                     compares  = 0;
   logic [DATA_W-1:0]      rd;
   logic [1:0]             rs;

   always #25 clk_sys_i = ~clk_sys_i;

   interrupt_factor_flags interrupt_factor_flags_i (
      .clk_sys_i    (clk_sys_i),
      .arst_n_i     (arst_n_i),
      .axil_req_i   (req),
      .axil_rsp_o   (rsp),
      .keyline_n_i  (keyline_n),
      .chrono_evt_i (chrono),
      .tick_evt_i   (tick),
      .irq_o        (irq)
   );

   // ----------------------------------------------------------------
   // Compare tasks
   // ----------------------------------------------------------------
   task automatic chk_data(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH %0t read data %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH %0t response %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_irq(input logic got, input logic exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH %0t interrupt %b expected %b", $time, got, exp);
      end
   endtask

   // ----------------------------------------------------------------
   // Bus tasks
   // ----------------------------------------------------------------
   function automatic logic [ADDR_W-1:0] ba(input logic [IDX_W-1:0] idx);
      return {idx, WORD_ALIGN};
   endfunction

   // Optional event pulse rides on the first bus cycle
   task automatic axi_write(input logic [IDX_W-1:0] idx, input logic [3:0] d,
                            input logic [STRB_W-1:0] strb, input tick_evt_s ev);
      logic aw;
      logic w;
      aw = 1'b1;
      w  = 1'b1;
      req.awvalid <= 1'b1;
      req.awaddr  <= ba(idx);
      req.wvalid  <= 1'b1;
      req.wdata   <= {28'h0000000, d};
      req.wstrb   <= strb;
      req.bready  <= 1'b1;
      tick        <= ev;
      do begin
         @(posedge clk_sys_i);
         if (aw || w) begin
            tick <= '0;
         end
         if (aw && rsp.awready) begin
            aw = 1'b0;
            req.awvalid <= 1'b0;
         end
         if (w && rsp.wready) begin
            w = 1'b0;
            req.wvalid <= 1'b0;
         end
      end while (aw || w || !rsp.bvalid);
      rs = rsp.bresp;
   endtask

   task automatic axi_read(input logic [IDX_W-1:0] idx);
      req.arvalid <= 1'b1;
      req.araddr  <= ba(idx);
      req.rready  <= 1'b1;
      do @(posedge clk_sys_i); while (!rsp.arready);
      req.arvalid <= 1'b0;
      do @(posedge clk_sys_i); while (!rsp.rvalid);
      rd = rsp.rdata;
      rs = rsp.rresp;
   endtask

   task automatic wr(input logic [IDX_W-1:0] idx, input logic [3:0] d);
      axi_write(idx, d, 4'hF, '0);
      chk_resp(rs, RESP_OKAY);
   endtask

   task automatic rd_chk(input logic [IDX_W-1:0] idx, input logic [DATA_W-1:0] exp);
      axi_read(idx);
      chk_data(rd, exp);
      chk_resp(rs, RESP_OKAY);
   endtask

   task automatic pulse(input chrono_evt_s c, input tick_evt_s t);
      chrono <= c;
      tick   <= t;
      @(posedge clk_sys_i);
      chrono <= '0;
      tick   <= '0;
      @(posedge clk_sys_i);
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      rd_chk(KEY_FLAGS_IDX, '0);
      rd_chk(SW_FLAGS_IDX, '0);
      rd_chk(TICK_FLAGS_IDX, '0);
      chk_irq(irq, 1'b0);
   endtask

   task automatic t_event(input logic [IDX_W-1:0] idx, input chrono_evt_s c,
                          input tick_evt_s t, input logic [3:0] exp);
      pulse(c, t);
      rd_chk(idx, {28'h0000000, exp});
      wr(idx, ~exp);
      rd_chk(idx, {28'h0000000, exp});
      wr(idx, exp);
      rd_chk(idx, '0);
   endtask

   task automatic t_keys();
      for (int i = 0; i < 4; i++) begin
         keyline_n <= ~(4'h1 << i);
         repeat (8) @(posedge clk_sys_i);
         keyline_n <= LINE_IDLE;
         rd_chk(KEY_FLAGS_IDX, 32'h1 << i);
         wr(KEY_FLAGS_IDX, 4'h1 << i);
         rd_chk(KEY_FLAGS_IDX, '0);
      end
   endtask

   task automatic t_priority();
      pulse('0, T128);
      axi_write(TICK_FLAGS_IDX, 4'h1, 4'hF, T128);
      rd_chk(TICK_FLAGS_IDX, 32'h1);
      axi_write(TICK_FLAGS_IDX, 4'h1, 4'h0, '0);
      chk_resp(rs, RESP_OKAY);
      rd_chk(TICK_FLAGS_IDX, 32'h1);
      wr(TICK_FLAGS_IDX, 4'h1);
      rd_chk(TICK_FLAGS_IDX, '0);
   endtask

   task automatic t_irq();
      wr(SW_MASK_IDX, 4'h2);
      pulse('{chrono_one_hz: 1'b1, default: 1'b0}, '0);
      chk_irq(irq, 1'b1);
      rd_chk(SW_MASK_IDX, 32'h2);
      wr(SW_MASK_IDX, 4'hD);
      chk_irq(irq, 1'b0);
      wr(SW_MASK_IDX, 4'h2);
      chk_irq(irq, 1'b1);
      wr(SW_FLAGS_IDX, 4'h2);
      chk_irq(irq, 1'b0);
      wr(TICK_MASK_IDX, 4'h1);
      rd_chk(TICK_MASK_IDX, 32'h1);
      pulse('0, T128);
      chk_irq(irq, 1'b1);
      wr(TICK_FLAGS_IDX, 4'h1);
      chk_irq(irq, 1'b0);
      wr(KEY_MASK_IDX, 4'h8);
      rd_chk(KEY_MASK_IDX, 32'h8);
      keyline_n <= 4'h7;
      repeat (8) @(posedge clk_sys_i);
      keyline_n <= LINE_IDLE;
      chk_irq(irq, 1'b1);
      wr(KEY_FLAGS_IDX, 4'h8);
      chk_irq(irq, 1'b0);
   endtask

   task automatic t_unmapped();
      axi_read(16'h0000);
      chk_data(rd, '0);
      chk_resp(rs, RESP_SLVERR);
      axi_write(16'h0000, 4'hF, 4'hF, '0);
      chk_resp(rs, RESP_SLVERR);
   endtask

   task automatic t_reset_mid();
      pulse('1, '1);
      arst_n_i <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
      arst_n_i <= 1'b1;
      @(posedge clk_sys_i);
      t_reset();
   endtask

   // ----------------------------------------------------------------
   // Sequence, verdict and watchdog
   // ----------------------------------------------------------------
   task automatic results();
      $display("Comparisons %0d, mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   initial begin
      repeat (5) @(posedge clk_sys_i);
      arst_n_i <= 1'b1;
      t_reset();
      t_event(SW_FLAGS_IDX, '{direct_go: 1'b1, default: 1'b0}, '0, 4'h8);
      t_event(SW_FLAGS_IDX, '{direct_split: 1'b1, default: 1'b0}, '0, 4'h4);
      t_event(SW_FLAGS_IDX, '{chrono_one_hz: 1'b1, default: 1'b0}, '0, 4'h2);
      t_event(SW_FLAGS_IDX, '{chrono_ten_hz: 1'b1, default: 1'b0}, '0, 4'h1);
      t_event(TICK_FLAGS_IDX, '0, '{tick_16hz: 1'b1, default: 1'b0}, 4'h8);
      t_event(TICK_FLAGS_IDX, '0, '{tick_32hz: 1'b1, default: 1'b0}, 4'h4);
      t_event(TICK_FLAGS_IDX, '0, '{tick_64hz: 1'b1, default: 1'b0}, 4'h2);
      t_event(TICK_FLAGS_IDX, '0, T128, 4'h1);
      t_keys();
      t_priority();
      t_irq();
      t_unmapped();
      t_reset_mid();
      results();
   end

   initial begin
      repeat (5000) @(posedge clk_sys_i);
      bad_count++;
      results();
   end

endmodule
